//--- design/hsl_strap_latch.sv
// hsl_strap_latch: latches hub strap pins when reset is released and
// drives the high-speed upstream indicator with the latched polarity.
// assumes strap pins and link status are synchronous to i_sys_clk and
// stable for at least one clock after i_resetn rises.

// Summary of operation
// - with the strap enabled, sample both fixed-port strap pins at reset release
// - code 00 marks all ports removable; 01 marks only port 1 fixed
// - code 10 fixes ports 1,2; 11 fixes ports 1,2,3 if port 3 exists
// - ignore the fixed-port strap unless package and config enable it
// - capture three config-select pins at reset release to pick config method
// - a missing third config-select pin reads as 0
// - indicator active high when latched select bit 1 is 0, else low
// - indicator asserted on high-speed link, negated on full speed
module hsl_strap_latch
	import hsl_pkg::*;
#(
	parameter int unsigned NUM_PORTS = HSL_PORTS_DEF,
	parameter logic [7:0] FIXED_CFG_EN = 8'hFF
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// strap pin levels and package options
	input wire hsl_strap_type i_strap,
	input wire logic i_pkg_has_cfg_sel2,
	input wire logic i_pkg_has_fixed_strap,
	// upstream link status
	input wire logic i_link_connected,
	input wire logic i_link_highspeed,
	// latched configuration
	output logic [HSL_CFG_W-1:0] o_cfg_method,
	output logic [NUM_PORTS-1:0] o_fixed_ports,
	output logic o_straps_valid,
	// indicator pin, enable low while driven
	output logic o_highspeed_link_indicator,
	output logic o_highspeed_link_indicator_oe_n
);

	// refuse port counts that the mask decode cannot serve
	if (NUM_PORTS < 1 || NUM_PORTS > HSL_PORTS_MAX) begin : g_bad_ports
		$error("NUM_PORTS out of range");
	end

	// decode a fixed-port strap code into a port mask
	function automatic logic [NUM_PORTS-1:0] fixed_mask(
		input logic [1:0] code
	);
		logic [HSL_PORTS_MAX-1:0] m;
		m = '0;
		unique case (code)
			HSL_FIX_NONE: m = 7'h00;
			HSL_FIX_P1: m = 7'h01;
			HSL_FIX_P12: m = 7'h03;
			HSL_FIX_P123: m = 7'h07;
		endcase
		return m[NUM_PORTS-1:0];
	endfunction

	hsl_state_type state_q, state_d;
	logic [HSL_CFG_W-1:0] cfg_q, cfg_d;
	logic [NUM_PORTS-1:0] fixed_q, fixed_d;
	logic valid_q, valid_d;
	logic ind_q, ind_d;
	logic oe_n_q, oe_n_d;
	logic [HSL_CFG_W-1:0] cfg_pins;
	logic fix_en;

	// third select bit forced to 0 when the pin is absent
	always_comb begin
		cfg_pins = i_strap.cfg_sel;
		if (!i_pkg_has_cfg_sel2) begin
			cfg_pins[HSL_CFG_SEL2_POS] = 1'b0;
		end
		fix_en = i_pkg_has_fixed_strap && FIXED_CFG_EN[cfg_pins];
	end

	// capture straps on the first clock after reset release, then hold
	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		fixed_d = fixed_q;
		valid_d = valid_q;
		unique case (state_q)
			HSL_CAPTURE: begin
				cfg_d = cfg_pins;
				if (fix_en) begin
					fixed_d = fixed_mask(i_strap.fixed_port_strap);
				end else begin
					fixed_d = '0;
				end
				valid_d = 1'b1;
				state_d = HSL_RUN;
			end
			HSL_RUN: begin
				state_d = HSL_RUN;
			end
		endcase
	end

	// indicator level and pin drive after straps are taken
	always_comb begin
		ind_d = 1'b0;
		oe_n_d = 1'b1;
		if (state_q == HSL_RUN) begin
			oe_n_d = 1'b0;
			// asserted only for a high-speed upstream connection
			ind_d = (i_link_connected && i_link_highspeed)
				^ cfg_q[HSL_CFG_POL_POS];
		end
	end

	// state registers; reset loads constants only
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= HSL_CAPTURE;
			cfg_q <= HSL_CFG_RST;
			fixed_q <= '0;
			valid_q <= 1'b0;
			ind_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			fixed_q <= fixed_d;
			valid_q <= valid_d;
			ind_q <= ind_d;
			oe_n_q <= oe_n_d;
		end
	end

	// outputs straight from flops
	assign o_cfg_method = cfg_q;
	assign o_fixed_ports = fixed_q;
	assign o_straps_valid = valid_q;
	assign o_highspeed_link_indicator = ind_q;
	assign o_highspeed_link_indicator_oe_n = oe_n_q;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	// capture takes exactly the pin code of the capture cycle
	chk_cfg_capture: assert property (
		state_q == HSL_CAPTURE |=> cfg_q == $past(cfg_pins)
	) else $error("config select not captured");

	// absent third pin reads as zero
	chk_sel2_absent: assert property (
		state_q == HSL_CAPTURE && !i_pkg_has_cfg_sel2
		|=> !cfg_q[HSL_CFG_SEL2_POS]
	) else $error("missing select pin not zero");

	// enabled strap decodes to the documented port mask
	chk_fixed_decode: assert property (
		state_q == HSL_CAPTURE && fix_en
		|=> fixed_q == fixed_mask($past(i_strap.fixed_port_strap))
	) else $error("fixed port mask wrong");

	// code 00 fixes nothing, 01 fixes only port 1
	chk_fixed_low: assert property (
		state_q == HSL_CAPTURE && fix_en
		&& i_strap.fixed_port_strap[1] == 1'b0
		|=> fixed_q[NUM_PORTS-1:0]
			== NUM_PORTS'($past(i_strap.fixed_port_strap[0]))
	) else $error("fixed code 00 or 01 mishandled");

	// code 11 fixes port 3 only when it exists
	chk_fixed_three: assert property (
		state_q == HSL_CAPTURE && fix_en
		&& i_strap.fixed_port_strap == HSL_FIX_P123
		|=> fixed_q[0] && (NUM_PORTS < 2 || fixed_q[NUM_PORTS > 1])
			&& (NUM_PORTS < 3 || fixed_q[NUM_PORTS > 2 ? 2 : 0])
	) else $error("fixed code 11 mishandled");

	// disabled strap leaves all ports removable
	chk_fixed_off: assert property (
		state_q == HSL_CAPTURE && !fix_en |=> fixed_q == '0
	) else $error("disabled strap honoured");

	// latched values never move while running
	chk_hold_latched: assert property (
		valid_q |=> $stable(cfg_q) && $stable(fixed_q) && valid_q
			&& !o_highspeed_link_indicator_oe_n
	) else $error("latched straps changed");

	// indicator follows link speed with the latched polarity
	chk_ind_level: assert property (
		state_q == HSL_RUN ##1 state_q == HSL_RUN
		|-> o_highspeed_link_indicator
			== (($past(i_link_connected) && $past(i_link_highspeed))
			^ cfg_q[HSL_CFG_POL_POS])
	) else $error("indicator level wrong");

	// full-speed link shows the negated level one cycle on
	chk_ind_fullspeed: assert property (
		state_q == HSL_RUN && i_link_connected && !i_link_highspeed
		|=> o_highspeed_link_indicator == cfg_q[HSL_CFG_POL_POS]
	) else $error("indicator not negated at full speed");

	// code 10 fixes ports 1 and 2 and nothing more
	chk_fixed_two: assert property (
		state_q == HSL_CAPTURE && fix_en
		&& i_strap.fixed_port_strap == HSL_FIX_P12
		|=> fixed_q == NUM_PORTS'(7'h03)
	) else $error("fixed code 10 mishandled");

	// capture happens on the first clock after release
	chk_capture_once: assert property (
		state_q == HSL_CAPTURE |=> o_straps_valid && state_q == HSL_RUN
	) else $error("straps not taken at release");

	// indicator pin stays released until straps are taken
	chk_pin_released: assert property (
		state_q == HSL_CAPTURE
		|-> o_highspeed_link_indicator_oe_n && !o_straps_valid
	) else $error("indicator driven during capture");

	// a link that is not connected shows the negated level
	chk_ind_unplugged: assert property (
		state_q == HSL_RUN && !i_link_connected
		|=> o_highspeed_link_indicator == cfg_q[HSL_CFG_POL_POS]
	) else $error("indicator not negated when unplugged");

endmodule

//--- pkg/hsl_pkg.sv
// hsl_pkg: constants and types for the hub reset strap latch.
// assumes one 125 MHz core clock and an asynchronous active-low reset.
package hsl_pkg;

	// core clock period and the shortest reset pulse the system must give
	localparam int unsigned HSL_CLK_PERIOD_NS = 8;
	localparam int unsigned HSL_RESET_MIN_NS = 1;
	localparam int unsigned HSL_RESET_MIN_CYC =
		(HSL_RESET_MIN_NS * 1000 + HSL_CLK_PERIOD_NS - 1) / HSL_CLK_PERIOD_NS;

	// field positions of the configuration-method select code
	localparam int unsigned HSL_CFG_W = 3;
	localparam int unsigned HSL_CFG_SEL2_POS = 2;
	localparam int unsigned HSL_CFG_POL_POS = 1;

	// fixed-port strap code width and codes
	localparam int unsigned HSL_FIX_W = 2;
	localparam logic [1:0] HSL_FIX_NONE = 2'h0;
	localparam logic [1:0] HSL_FIX_P1 = 2'h1;
	localparam logic [1:0] HSL_FIX_P12 = 2'h2;
	localparam logic [1:0] HSL_FIX_P123 = 2'h3;

	// documented port count and reset values of latched state
	localparam int unsigned HSL_PORTS_DEF = 7;
	localparam int unsigned HSL_PORTS_MAX = 7;
	localparam logic [2:0] HSL_CFG_RST = 3'h0;
	localparam logic [1:0] HSL_FIX_RST = 2'h0;

	// latch sequence: capture once after release, then hold
	typedef enum logic {
		HSL_CAPTURE = 1'b0,
		HSL_RUN = 1'b1
	} hsl_state_type;

	// strap pin levels as presented at the shared pins
	typedef struct packed {
		logic [2:0] cfg_sel;
		logic [1:0] fixed_port_strap;
	} hsl_strap_type;

endpackage

//--- verification/hsl_board_model.sv
// hsl_board_model: strap resistors and system reset driver.
// assumes the bench pulses i_go for one cycle to request a reset.
module hsl_board_model
	import hsl_pkg::*;
(
	// clock and request
	input wire logic i_sys_clk,
	input wire logic i_go,
	input wire hsl_strap_type i_level,
	// board side pins
	output logic o_resetn,
	output hsl_strap_type o_strap
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// pins idle in reset with straps applied
	initial begin
		o_resetn = 1'b0;
		o_strap = '0;
	end
	// hold reset long enough, then pins go to serial use
	always @(negedge i_sys_clk) begin
		if (i_go) begin
			cnt = 0;
			o_resetn = 1'b0;
			o_strap = i_level;
		end else begin
			cnt = cnt + 1;
			if (cnt >= HSL_RESET_MIN_CYC) o_resetn = 1'b1;
			if (cnt >= HSL_RESET_MIN_CYC + 2) o_strap = ~o_strap;
		end
	end
endmodule

//--- verification/hsl_strap_latch_tb_top.sv
// hsl_strap_latch_tb_top: strap latch bench, one reset per case.
// assumes hsl_board_model drives reset and strap pins.
module hsl_strap_latch_tb_top
	import hsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0;
	logic go = 1'b1;
	logic has_sel2 = 1'b0;
	logic has_fix = 1'b0;
	logic conn = 1'b0;
	logic hs = 1'b0;
	logic i_resetn, valid, ind, oe_n;
	hsl_strap_type level = '0;
	hsl_strap_type strap;
	logic [2:0] cfg, e_cfg;
	logic [6:0] fixp, e_fix;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int w;
	// clock
	always #4 i_sys_clk = ~i_sys_clk;
	hsl_board_model i_board(.i_sys_clk(i_sys_clk), .i_go(go),
		.i_level(level), .o_resetn(i_resetn), .o_strap(strap));
	hsl_strap_latch #(.NUM_PORTS(7), .FIXED_CFG_EN(8'h0F)) i_dut(
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_strap(strap),
		.i_pkg_has_cfg_sel2(has_sel2), .i_pkg_has_fixed_strap(has_fix),
		.i_link_connected(conn), .i_link_highspeed(hs),
		.o_cfg_method(cfg), .o_fixed_ports(fixp), .o_straps_valid(valid),
		.o_highspeed_link_indicator(ind),
		.o_highspeed_link_indicator_oe_n(oe_n));
	// compare and count
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// hang guard
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			test_done();
		end
	end
	// each case: strap levels, package options, reset, link sweep
	initial begin
		repeat (3) @(negedge i_sys_clk);
		for (int i = 0; i < 16; i++) begin
			has_sel2 = i[0] ^ i[3];
			has_fix = !i[3];
			e_cfg = 3'(i * 3);
			e_cfg[2] = e_cfg[2] & has_sel2;
			e_fix = (has_fix && e_cfg < 3'h4) ? (7'h1 << i[1:0]) - 7'h1 : 7'h0;
			level <= {3'(i * 3), 2'(i)};
			go <= 1'b1;
			@(negedge i_sys_clk);
			go <= 1'b0;
			@(negedge i_sys_clk);
			check("oe_n reset", 8'(oe_n), 8'h01);
			check("valid reset", 8'(valid), 8'h00);
			w = 0;
			while (valid !== 1'b1 && w < 400) begin
				@(negedge i_sys_clk);
				w++;
			end
			check("valid", 8'(valid), 8'h01);
			check("cfg", 8'(cfg), 8'(e_cfg));
			check("fixed", 8'(fixp), 8'(e_fix));
			for (int j = 0; j < 4; j++) begin
				conn = j[1];
				hs = j[0];
				repeat (2) @(negedge i_sys_clk);
				check("ind", 8'(ind), 8'((conn & hs) ^ e_cfg[1]));
			end
			check("oe_n run", 8'(oe_n), 8'h00);
			check("cfg held", 8'(cfg), 8'(e_cfg));
			check("fixed held", 8'(fixp), 8'(e_fix));
			$display("test %0d done", i);
		end
		test_done();
	end
endmodule
